// file: hw/track_cfg_pkg.sv
// Constants and carrier types for the button-algorithm tracking configuration slice.
// Assumes a register access port that is synchronous to sys_clk.
package track_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] LOW_POWER_TRACK_STEP_OFS = 8'h13;
  localparam logic [7:0] CHAN3_GAIN_OFS = 8'h14;
  localparam logic [7:0] NORMAL_POWER_TRACK_STEP_OFS = 8'h15;
  localparam logic [7:0] TRACK_PAUSE_AND_GROUP_SELECT_OFS = 8'h16;
  localparam logic [7:0] OSCILLATION_DIVIDER_OFS = 8'h17;

  localparam logic [2:0] LOW_POWER_TRACK_INCREMENT_RST = 3'h5;
  localparam logic [5:0] CHAN3_SENSITIVITY_RST = 6'h28;
  localparam logic [2:0] NORMAL_POWER_TRACK_INCREMENT_RST = 3'h3;
  localparam logic [3:0] TRACK_HOLD_RST = 4'h0;
  localparam logic [3:0] STRONGEST_GROUP_RST = 4'h0;
  localparam logic [2:0] RESONATOR_FREQ_DIVIDE_RST = 3'h3;

  // Field positions
  localparam int TRACK_INCREMENT_LSB = 0;
  localparam int SENSITIVITY_LSB = 0;
  localparam int TRACK_HOLD_LSB = 4;
  localparam int STRONGEST_GROUP_LSB = 0;
  localparam int FREQ_DIVIDE_LSB = 0;

  localparam int NUM_CHAN = 4;
  localparam int CYCLE_COUNT_W = 12;

  typedef struct packed {
    logic write;
    logic read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_t;

endpackage

// file: hw/sample_window_timer.sv
// Sampling window timer: prescales resonator ticks by two to the divide setting
// and counts sensor cycles of prescaled ticks. Inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sample_window_timer #(
  parameter int CW = track_cfg_pkg::CYCLE_COUNT_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic oscTick,
  input wire logic [2:0] freqDivide,
  input wire logic [CW-1:0] sensorCycleCount,
  output logic windowDone
);
  import track_cfg_pkg::*;

  logic [7:0] prescale_q;
  logic [7:0] prescale_d;
  logic [7:0] prescaleLast;
  logic [CW-1:0] cycles_q;
  logic [CW-1:0] cycles_d;
  logic [CW-1:0] cycleLast;
  logic divTick;
  logic lastCycle;
  logic windowDone_q;

  assign prescaleLast = 8'((9'h001 << freqDivide) - 9'h001);
  assign divTick = oscTick && (prescale_q >= prescaleLast);
  assign prescale_d = !oscTick ? prescale_q : (divTick ? 8'h00 : 8'(prescale_q + 8'h01));
  // A zero count would wrap to the largest count, so it behaves as one cycle
  assign cycleLast = (sensorCycleCount == '0) ? '0 : CW'(sensorCycleCount - 1'b1);
  assign lastCycle = divTick && (cycles_q >= cycleLast);
  assign cycles_d = !divTick ? cycles_q : (lastCycle ? '0 : CW'(cycles_q + 1'b1));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prescale_q <= 8'h00;
      cycles_q <= '0;
      windowDone_q <= 1'b0;
    end else begin
      prescale_q <= prescale_d;
      cycles_q <= cycles_d;
      windowDone_q <= lastCycle;
    end
  end

  assign windowDone = windowDone_q;

endmodule
`default_nettype wire

// file: hw/button_algo_tracking_config_regs.sv
// Tracking, gain, pause, group and divider configuration of the button algorithm.
// Assumes the serial front end issues one-cycle read/write strobes on sys_clk.
// Overview of operation
// - Low-power tracking increment is bits 2-0 of its register, reset 5h.
// - Channel 3 gain is six bits 5-0, reset 28h, fed to detection.
// - Normal-power tracking increment is bits 2-0; register resets to 03h.
// - Set hold bit (7..4 for channels 3..0) stops tracking while output asserted.
// - Clear hold bit keeps tracking regardless of that channel's output while press detection is enabled.
// - Bits 3..0 put channels 3..0 in the strongest-press group when set, while press detection is enabled.
// - Divider bits 2-0, reset 3h, with cycle count set window length.
// - Button outputs show events only while press detection is enabled.
`timescale 1ns/1ps
`default_nettype none
module button_algo_tracking_config_regs #(
  parameter int CW = track_cfg_pkg::CYCLE_COUNT_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire track_cfg_pkg::reg_req_t regReq,
  output var track_cfg_pkg::reg_rsp_t regRsp,
  input wire logic pressDetectEnable,
  input wire logic lowPowerMode,
  input wire logic [3:0] pressDetected,
  input wire logic oscTick,
  input wire logic [CW-1:0] sensorCycleCount,
  output logic [3:0] buttonOutput,
  output logic [3:0] trackEnable,
  output logic [2:0] trackStep,
  output logic [5:0] chan3Sensitivity,
  output logic [3:0] strongestGroup,
  output logic windowDone
);
  import track_cfg_pkg::*;

  logic [2:0] lowPowerTrackIncrement_q;
  logic [5:0] chan3Gain_q;
  logic [2:0] normalPowerTrackIncrement_q;
  logic [3:0] trackHold_q;
  logic [3:0] strongestGroupBits_q;
  logic [2:0] resonatorFreqDivide_q;
  logic [3:0] buttonOutput_q;
  logic [3:0] buttonOutput_d;
  logic [3:0] trackEnable_q;
  logic [3:0] trackEnable_d;
  logic [2:0] trackStep_q;
  logic [2:0] trackStep_d;
  logic [5:0] chan3Sensitivity_q;
  logic [3:0] strongestGroup_q;
  reg_rsp_t regRsp_q;
  reg_rsp_t regRsp_d;
  logic [7:0] readData;
  logic wrLowStep;
  logic wrGain;
  logic wrNormStep;
  logic wrPauseGroup;
  logic wrDivide;
  logic windowDoneRaw;
  logic windowDone_q;

  function automatic logic hit(input reg_req_t req, input logic [7:0] ofs);
    hit = req.write && (req.addr == ofs);
  endfunction

  assign wrLowStep = hit(regReq, LOW_POWER_TRACK_STEP_OFS);
  assign wrGain = hit(regReq, CHAN3_GAIN_OFS);
  assign wrNormStep = hit(regReq, NORMAL_POWER_TRACK_STEP_OFS);
  assign wrPauseGroup = hit(regReq, TRACK_PAUSE_AND_GROUP_SELECT_OFS);
  assign wrDivide = hit(regReq, OSCILLATION_DIVIDER_OFS);

  // Reserved bits are not stored and read back as zero
  assign readData =
    (regReq.addr == LOW_POWER_TRACK_STEP_OFS) ? {5'h00, lowPowerTrackIncrement_q} :
    (regReq.addr == CHAN3_GAIN_OFS) ? {2'h0, chan3Gain_q} :
    (regReq.addr == NORMAL_POWER_TRACK_STEP_OFS) ? {5'h00, normalPowerTrackIncrement_q} :
    (regReq.addr == TRACK_PAUSE_AND_GROUP_SELECT_OFS) ? {trackHold_q, strongestGroupBits_q} :
    (regReq.addr == OSCILLATION_DIVIDER_OFS) ? {5'h00, resonatorFreqDivide_q} :
    8'h00;
  assign regRsp_d = '{valid: regReq.read, rdata: regReq.read ? readData : 8'h00};

  assign buttonOutput_d = pressDetectEnable ? pressDetected : 4'h0;
  // Hold only bites on a channel whose output is currently asserted; a held channel
  // resumes one cycle after its output drops, because the output is registered
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    assign trackEnable_d[ch] =
      pressDetectEnable && !(trackHold_q[ch] && buttonOutput_q[ch]);

    chk_hold_chan: assert property (@(posedge sys_clk) disable iff (!resetn)
      trackHold_q[ch] && buttonOutput_q[ch] |=> !trackEnable_q[ch])
      else $error("held channel kept tracking");

    chk_free_chan: assert property (@(posedge sys_clk) disable iff (!resetn)
      resetn && pressDetectEnable && !trackHold_q[ch] |=> trackEnable_q[ch])
      else $error("free channel stopped tracking");
  end
  assign trackStep_d = lowPowerMode ? lowPowerTrackIncrement_q
                                    : normalPowerTrackIncrement_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lowPowerTrackIncrement_q <= LOW_POWER_TRACK_INCREMENT_RST;
      chan3Gain_q <= CHAN3_SENSITIVITY_RST;
      normalPowerTrackIncrement_q <= NORMAL_POWER_TRACK_INCREMENT_RST;
      trackHold_q <= TRACK_HOLD_RST;
      strongestGroupBits_q <= STRONGEST_GROUP_RST;
      resonatorFreqDivide_q <= RESONATOR_FREQ_DIVIDE_RST;
    end else begin
      if (wrLowStep) begin
        lowPowerTrackIncrement_q <= regReq.wdata[TRACK_INCREMENT_LSB +: 3];
      end
      if (wrGain) begin
        chan3Gain_q <= regReq.wdata[SENSITIVITY_LSB +: 6];
      end
      if (wrNormStep) begin
        normalPowerTrackIncrement_q <= regReq.wdata[TRACK_INCREMENT_LSB +: 3];
      end
      if (wrPauseGroup) begin
        trackHold_q <= regReq.wdata[TRACK_HOLD_LSB +: 4];
        strongestGroupBits_q <= regReq.wdata[STRONGEST_GROUP_LSB +: 4];
      end
      if (wrDivide) begin
        resonatorFreqDivide_q <= regReq.wdata[FREQ_DIVIDE_LSB +: 3];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      buttonOutput_q <= 4'h0;
      trackEnable_q <= 4'h0;
      trackStep_q <= NORMAL_POWER_TRACK_INCREMENT_RST;
      chan3Sensitivity_q <= CHAN3_SENSITIVITY_RST;
      strongestGroup_q <= STRONGEST_GROUP_RST;
      regRsp_q <= '0;
      windowDone_q <= 1'b0;
    end else begin
      buttonOutput_q <= buttonOutput_d;
      trackEnable_q <= trackEnable_d;
      trackStep_q <= trackStep_d;
      chan3Sensitivity_q <= chan3Gain_q;
      strongestGroup_q <= pressDetectEnable ? strongestGroupBits_q : 4'h0;
      regRsp_q <= regRsp_d;
      windowDone_q <= windowDoneRaw;
    end
  end

  sample_window_timer #(
    .CW(CW)
  ) u_window (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .oscTick(oscTick),
    .freqDivide(resonatorFreqDivide_q),
    .sensorCycleCount(sensorCycleCount),
    .windowDone(windowDoneRaw)
  );

  assign buttonOutput = buttonOutput_q;
  assign trackEnable = trackEnable_q;
  assign trackStep = trackStep_q;
  assign chan3Sensitivity = chan3Sensitivity_q;
  assign strongestGroup = strongestGroup_q;
  assign regRsp = regRsp_q;
  assign windowDone = windowDone_q;

  chk_low_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrLowStep && lowPowerMode ##1 lowPowerMode |=> trackStep_q == $past(regReq.wdata[2:0], 2))
    else $error("low-power increment not applied");

  chk_norm_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrNormStep && !lowPowerMode ##1 !lowPowerMode |=> trackStep_q == $past(regReq.wdata[2:0], 2))
    else $error("normal-power increment not applied");

  chk_gain_path: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrGain |=> ##1 chan3Sensitivity_q == $past(regReq.wdata[5:0], 2))
    else $error("channel 3 gain not applied");

  chk_hold_stops: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 (($past(trackHold_q & buttonOutput_q) & trackEnable_q) == 4'h0))
    else $error("tracking ran on a held asserted channel");

  chk_no_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    resetn && pressDetectEnable && trackHold_q == 4'h0 |=> trackEnable_q == 4'hf)
    else $error("tracking stopped with hold cleared");

  chk_group_bits: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrPauseGroup && pressDetectEnable ##1 pressDetectEnable
      |=> strongestGroup_q == $past(regReq.wdata[3:0], 2))
    else $error("group membership not applied");

  chk_out_gated: assert property (@(posedge sys_clk) disable iff (!resetn)
    !pressDetectEnable |=> buttonOutput_q == 4'h0 && trackEnable_q == 4'h0)
    else $error("output event while detection disabled");

  chk_out_follow: assert property (@(posedge sys_clk) disable iff (!resetn)
    resetn && pressDetectEnable |=> buttonOutput_q == $past(pressDetected))
    else $error("button output does not follow detection");

  chk_div_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrDivide ##1 (regReq.read && regReq.addr == OSCILLATION_DIVIDER_OFS && !regReq.write)
      |=> regRsp_q.valid && regRsp_q.rdata == {5'h00, $past(regReq.wdata[2:0], 2)})
    else $error("divider readback wrong");

  chk_low_select: assert property (@(posedge sys_clk) disable iff (!resetn)
    resetn && lowPowerMode |=> trackStep_q == $past(lowPowerTrackIncrement_q))
    else $error("low-power increment not selected");

  chk_norm_select: assert property (@(posedge sys_clk) disable iff (!resetn)
    resetn && !lowPowerMode |=> trackStep_q == $past(normalPowerTrackIncrement_q))
    else $error("normal-power increment not selected");

  chk_low_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    regReq.read && regReq.addr == LOW_POWER_TRACK_STEP_OFS
      |=> regRsp_q.valid && regRsp_q.rdata == {5'h00, $past(lowPowerTrackIncrement_q)})
    else $error("low-power increment readback wrong");

  chk_gain_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    regReq.read && regReq.addr == CHAN3_GAIN_OFS
      |=> regRsp_q.valid && regRsp_q.rdata == {2'h0, $past(chan3Gain_q)})
    else $error("channel 3 gain readback wrong");

  chk_pause_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    regReq.read && regReq.addr == TRACK_PAUSE_AND_GROUP_SELECT_OFS
      |=> regRsp_q.valid
        && regRsp_q.rdata == {$past(trackHold_q), $past(strongestGroupBits_q)})
    else $error("hold and group readback wrong");

  chk_window_tick: assert property (@(posedge sys_clk) disable iff (!resetn)
    windowDone_q |-> $past(oscTick, 2))
    else $error("window ended without a resonator tick");

endmodule
`default_nettype wire

// file: tb/host_model.sv
// Host side of the register port: one strobe per request, reads wait for the answer.
// Assumes the bench calls these tasks hierarchically and sys_clk is running.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output var track_cfg_pkg::reg_req_t regReq,
  input wire track_cfg_pkg::reg_rsp_t regRsp
);
  import track_cfg_pkg::*;
  initial regReq = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    regReq <= '0;
  endtask
  // Bounded wait so a silent port ends the run instead of hanging it; the answer
  // is taken at the edge after the request, before that edge clears it
  task automatic takeRsp(output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge sys_clk);
      if (regRsp.valid === 1'b1) begin
        ok = 1'b1;
        d = regRsp.rdata;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge sys_clk);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    regReq <= '0;
    takeRsp(d, ok);
  endtask
  // Write and read back in adjacent cycles, the tightest order the port allows
  task automatic wrRd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d,
                      output logic ok);
    @(posedge sys_clk);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: wd};
    @(posedge sys_clk);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    regReq <= '0;
    takeRsp(d, ok);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the tracking configuration slice.
// Assumes host_model drives the register port; the bench drives the algorithm side.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import track_cfg_pkg::*;
  logic sys_clk, resetn, pressDetectEnable, lowPowerMode, oscTick;
  logic [3:0] pressDetected, buttonOutput, trackEnable, strongestGroup;
  logic [11:0] sensorCycleCount;
  logic [2:0] trackStep;
  logic [5:0] chan3Sensitivity;
  logic windowDone;
  reg_req_t regReq;
  reg_rsp_t regRsp;
  int numErrors = 0, samplesChecked = 0, windowCount = 0, i;
  logic [7:0] addrs [5] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
  logic [7:0] rstVals [5] = '{8'h05, 8'h28, 8'h03, 8'h00, 8'h03};
  logic [7:0] maskVals [5] = '{8'h07, 8'h3f, 8'h07, 8'hff, 8'h07};

  host_model host_u (.sys_clk(sys_clk), .regReq(regReq), .regRsp(regRsp));
  button_algo_tracking_config_regs dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .regReq(regReq), .regRsp(regRsp), .pressDetectEnable(pressDetectEnable),
    .lowPowerMode(lowPowerMode), .pressDetected(pressDetected), .oscTick(oscTick),
    .sensorCycleCount(sensorCycleCount), .buttonOutput(buttonOutput),
    .trackEnable(trackEnable), .trackStep(trackStep), .chan3Sensitivity(chan3Sensitivity),
    .strongestGroup(strongestGroup), .windowDone(windowDone));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (windowDone === 1'b1) windowCount++;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A missing answer ends the run at once, counted as a mismatch
  task automatic gotChk(input logic [7:0] a, input logic [7:0] d, input logic ok,
                        input logic [7:0] exp);
    if (!ok) begin
      numErrors++;
      reportAndStop();
    end else begin
      check($sformatf("reg %h", a), d, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.rd(a, d, ok);
    gotChk(a, d, ok, exp);
  endtask
  task automatic wrRdChk(input logic [7:0] a, input logic [7:0] wd, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.wrRd(a, wd, d, ok);
    gotChk(a, d, ok, exp);
  endtask
  // Outputs are looked at on the edge itself, before that edge updates them
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  initial begin
    resetn = 1'b0;
    pressDetectEnable = 1'b1;
    lowPowerMode = 1'b0;
    pressDetected = 4'h0;
    oscTick = 1'b0;
    sensorCycleCount = 12'h002;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) rdChk(addrs[i], rstVals[i]);
    settle(1);
    check("gain", {2'h0, chan3Sensitivity}, 8'h28);
    check("step", {5'h00, trackStep}, 8'h03);
    $display("test reset values done");
    // Reserved bits are dropped, so only the fields read back
    for (i = 0; i < 5; i++) host_u.wr(addrs[i], 8'hff);
    for (i = 0; i < 5; i++) rdChk(addrs[i], maskVals[i]);
    host_u.wr(8'h13, 8'hfa);
    rdChk(8'h13, 8'h02);
    rdChk(8'h20, 8'h00);
    check("gain", {2'h0, chan3Sensitivity}, 8'h3f);
    check("step", {5'h00, trackStep}, 8'h07);
    lowPowerMode <= 1'b1;
    settle(2);
    check("step", {5'h00, trackStep}, 8'h02);
    host_u.wr(8'h13, 8'hfc);
    settle(2);
    check("step", {5'h00, trackStep}, 8'h04);
    lowPowerMode <= 1'b0;
    $display("test field access done");
    pressDetected <= 4'hf;
    settle(3);
    check("out", {4'h0, buttonOutput}, 8'h0f);
    check("track", {4'h0, trackEnable}, 8'h00);
    check("group", {4'h0, strongestGroup}, 8'h0f);
    host_u.wr(8'h16, 8'h5a);
    settle(3);
    check("track", {4'h0, trackEnable}, 8'h0a);
    check("group", {4'h0, strongestGroup}, 8'h0a);
    pressDetectEnable <= 1'b0;
    settle(3);
    check("out", {4'h0, buttonOutput}, 8'h00);
    check("group", {4'h0, strongestGroup}, 8'h00);
    pressDetectEnable <= 1'b1;
    $display("test hold and group done");
    // Divide by two then by one; two prescaled ticks close each window
    for (i = 1; i >= 0; i--) begin
      wrRdChk(8'h17, 8'(i), 8'(i));
      windowCount = 0;
      repeat (8) begin
        @(posedge sys_clk) oscTick <= 1'b1;
        @(posedge sys_clk) oscTick <= 1'b0;
      end
      settle(4);
      check("windows", 8'(windowCount), 8'(4 >> i));
    end
    $display("test sampling window done");
    resetn <= 1'b0;
    settle(2);
    check("step", {5'h00, trackStep}, 8'h03);
    check("gain", {2'h0, chan3Sensitivity}, 8'h28);
    check("out", {4'h0, buttonOutput}, 8'h00);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) rdChk(addrs[i], rstVals[i]);
    $display("test mid-run reset done");
    reportAndStop();
  end
endmodule
`default_nettype wire
